// ### bench/irap_assertions.sv
// checker on the i2c pair and the device register port
// assumes one mclk domain with a sync low reset
module irap_assertions (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        scl,
    input wire logic        sda,
    input wire logic        sdaOeS,
    input wire logic        regReq,
    input wire logic        regAck,
    input wire logic        regWrite,
    input wire logic [4:0]  regPort,
    input wire logic [11:0] regAddr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // pending request; start condition made by the host
    sequence s_wait; regReq && !regAck; endsequence
    sequence s_start; scl && $past(scl) && $fell(sda); endsequence
    property p_hold; s_wait |=> regReq && $stable({regAddr, regPort, regWrite}); endproperty
    property p_drop; regReq && regAck |=> !regReq; endproperty
    property p_align; regReq |-> regAddr[1:0] == 2'b00; endproperty
    property p_reqLow; $rose(regReq) |-> !scl; endproperty
    property p_devChg; $changed(sdaOeS) |-> !scl; endproperty
    property p_ackHold; $rose(sdaOeS) |=> sdaOeS [*6]; endproperty
    property p_noStart; s_start |-> !sdaOeS; endproperty
    // an all-zero byte holds sda longest, so the bound covers nine bits
    property p_release; sdaOeS |-> ##[0:160] !sdaOeS; endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    a_drop: assert property (p_drop) else $error("request kept");
    a_align: assert property (p_align) else $error("unaligned");
    a_reqLow: assert property (p_reqLow) else $error("request off slot");
    a_devChg: assert property (p_devChg) else $error("sda moved, scl high");
    a_ackHold: assert property (p_ackHold) else $error("short pull");
    a_noStart: assert property (p_noStart) else $error("device start");
    a_release: assert property (p_release) else $error("sda stuck");
endmodule

// ### bench/tb.sv
// bench: host end and device end joined on one i2c pair
// assumes a register side, modelled here, that answers one cycle late
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import irap_pkg::*;
    typedef struct {logic rd; logic [4:0] port; logic [3:0] be; logic [11:0] addr;
        logic [31:0] wd; logic [31:0] exp;} irap_row_t;
    logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        regAck = 1'b0, pready, pslverr, regReq, regWrite, capWr;
    logic [7:0]  paddr = 8'h00;
    logic [2:0]  strap = 3'h0;
    logic [31:0] pwdata = 32'h0, regRdata = 32'h0, prdata, regWdata;
    logic [4:0]  regPort, capPort;
    logic [11:0] regAddr, capAddr;
    logic [3:0]  regBe, capBe;
    bit   [31:0] mem [32][1024];
    int          err_count = 0, total_checks = 0, reqCount = 0;
    // writes hold the stored word as expectation, reads the returned word
    irap_row_t   rows [7] = '{
        '{1'b0, 5'h00, 4'hf, 12'h0fb, 32'h12345678, 32'h12345678},
        '{1'b0, 5'h02, 4'h5, 12'hffc, 32'h11223344, 32'h00220044},
        '{1'b0, 5'h01, 4'ha, 12'h004, 32'hdeadbeef, 32'hde00be00},
        '{1'b0, 5'h1f, 4'h8, 12'h800, 32'h9abcdef0, 32'h9a000000},
        '{1'b1, 5'h00, 4'hf, 12'h0f8, 32'h0, 32'h12345678},
        '{1'b1, 5'h02, 4'hf, 12'hffc, 32'h0, 32'h00220044},
        '{1'b1, 5'h1f, 4'hf, 12'h800, 32'h0, 32'h9a000000}};
    irap_i2c_if link ();
    irap_host u_irap_host (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .bus(link.host));
    irap_dev u_irap_dev (.mclk, .rst_n, .bus(link.dev), .addrStrap(strap), .regReq,
        .regWrite, .regPort, .regAddr, .regBe, .regWdata, .regRdata, .regAck);
    irap_assertions u_irap_assertions (.mclk, .rst_n, .scl(link.scl), .sda(link.sda),
        .sdaOeS(link.sdaOeS), .regReq, .regAck, .regWrite, .regPort, .regAddr);
    always #5 mclk = ~mclk;
    // register side: one-cycle answer, byte enables applied here
    always @(posedge mclk) begin
        regAck <= (regReq === 1'b1) && !regAck;
        if (regReq === 1'b1 && !regAck) begin
            reqCount <= reqCount + 1;
            {capPort, capAddr, capBe, capWr} <= {regPort, regAddr, regBe, regWrite};
            regRdata <= mem[regPort][regAddr[11:2]];
            for (int i = 0; i < 4; i++)
                if (regWrite && regBe[i])
                    mem[regPort][regAddr[11:2]][8*i +: 8] <= regWdata[8*i +: 8];
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // apb cycle; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge mclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // one access through the host registers, polled until idle
    task automatic run(input irap_row_t r, output logic [31:0] s);
        logic e;
        apb(1'b1, OFF_TARGET, {4'h0, r.addr, 4'h0, r.be, 3'h0, r.port}, s, e);
        apb(1'b1, OFF_WDATA, r.wd, s, e);
        apb(1'b1, OFF_CTRL, {30'h0, r.rd, 1'b1}, s, e);
        do
            apb(1'b0, OFF_STATUS, 32'h0, s, e);
        while (s[STAT_BUSY] !== 1'b0);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog: a full run needs under 20000 cycles
    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        wrap_up();
    end
    initial begin
        logic [31:0] v;
        logic        e;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b0, 8'h18, 32'h0, v, e);
        chk({v[30:0], e}, 32'h1);
        foreach (rows[i]) begin
            run(rows[i], v);
            chk(32'(reqCount), 32'(i + 1));
            chk(32'(capPort), 32'(rows[i].port));
            chk(32'(capAddr), 32'({rows[i].addr[11:2], 2'b00}));
            chk(32'(capBe), 32'(rows[i].be));
            chk(32'(capWr), 32'(!rows[i].rd));
            if (rows[i].rd)
                apb(1'b0, OFF_RDATA, 32'h0, v, e);
            else
                v = mem[rows[i].port][rows[i].addr[11:2]];
            chk(v, rows[i].exp);
        end
        // foreign slave address: no ack, no request
        apb(1'b1, OFF_SLAVE, 32'h69, v, e);
        run(rows[0], v);
        chk(v & 32'h3, 32'h2);
        chk(32'(reqCount), 32'h7);
        // straps only count at reset, so move them and reset mid-run
        strap <= 3'h1;
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b0, OFF_SLAVE, 32'h0, v, e);
        chk(v, 32'h68);
        apb(1'b1, OFF_SLAVE, 32'h69, v, e);
        run(rows[4], v);
        chk(v & 32'h3, 32'h0);
        apb(1'b0, OFF_RDATA, 32'h0, v, e);
        chk(v, rows[4].exp);
        chk(32'(reqCount), 32'h8);
        wrap_up();
    end
endmodule

// ### rtl/irap_dev.sv
// device end: i2c slave giving 32-bit access to a register port
// assumes the register side answers regReq with regAck, one pulse

module irap_dev (
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    irap_i2c_if.dev                          bus,
    input  wire logic [irap_pkg::STRAP_W-1:0] addrStrap,
    output logic                             regReq,
    output logic                             regWrite,
    output logic [irap_pkg::PSEL_W-1:0]      regPort,
    output logic [irap_pkg::ADDR_W-1:0]      regAddr,
    output logic [irap_pkg::BE_W-1:0]        regBe,
    output logic [31:0]                      regWdata,
    input  wire logic [31:0]                 regRdata,
    input  wire logic                        regAck
);
    import irap_pkg::*;

    typedef enum logic [2:0] {IDLE, RECV, ACK, SEND, MACK} irap_dev_st_t;

    irap_dev_st_t        st_reg;
    irap_dev_st_t        st_next;
    logic [1:0]          sclSync_reg;
    logic [1:0]          sdaSync_reg;
    logic                sclPrev_reg;
    logic                sdaPrev_reg;
    logic [STRAP_W-1:0]  strapS1_reg;
    logic [STRAP_W-1:0]  strapS2_reg;
    logic [STRAP_W-1:0]  strap_reg;
    logic [1:0]          strapCnt_reg;
    logic [3:0]          bitCnt_reg;
    logic [7:0]          shift_reg;
    logic                isAddr_reg;
    logic                rdMode_reg;
    logic [3:0]          byteCnt_reg;
    logic [2:0]          op_reg;
    logic [PSEL_W-1:0]   port_reg;
    logic [BE_W-1:0]     be_reg;
    logic [ADDR_W-1:0]   addr_reg;
    logic [31:0]         wdata_reg;
    logic [31:0]         hold_reg;
    logic [7:0]          txShift_reg;
    logic [1:0]          txIdx_reg;
    logic                mAck_reg;
    logic                sdaOe_reg;
    logic                sdaOe_next;
    logic                launch_reg;
    logic                launchWr_reg;
    logic                req_reg;
    logic                write_reg;

    // synchronised line levels and their edges
    wire sclS      = sclSync_reg[1];
    wire sdaS      = sdaSync_reg[1];
    wire sclRise   = sclS & ~sclPrev_reg;
    wire sclFall   = ~sclS & sclPrev_reg;
    wire startSeen = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
    wire stopSeen  = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;

    // byte completion and decode
    wire       byteDone = (st_reg == RECV) & sclFall & (bitCnt_reg == BIT_ACK);
    wire [6:0] myAddr   = {SLV_ADDR_BASE[6:3], strap_reg};
    wire       addrHit  = shift_reg[7:1] == myAddr;
    wire       takeByte = byteDone & ~isAddr_reg;
    wire       ackByte  = takeByte | (byteDone & addrHit);
    wire [1:0] wIdx     = ~byteCnt_reg[1:0];
    wire       rdLaunch = takeByte & (byteCnt_reg == CMD_LAST) & (op_reg == OP_READ);
    wire       wrLaunch = takeByte & (byteCnt_reg == DATA_LAST) & (op_reg == OP_WRITE);
    wire [7:0] txByte   = hold_reg[{~txIdx_reg, 3'b000} +: 8];
    wire       sendEnd  = (st_reg == SEND) & sclFall & (bitCnt_reg == 4'h7);
    wire       ackEnd   = (st_reg == ACK) & sclFall;
    wire       mackEnd  = (st_reg == MACK) & sclFall;
    wire       loadTx   = (ackEnd & rdMode_reg) | (mackEnd & mAck_reg);

    // pins are asynchronous: two flops before any use
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclSync_reg <= {sclSync_reg[0], bus.scl};
            sdaSync_reg <= {sdaSync_reg[0], bus.sda};
            sclPrev_reg <= sclS;
            sdaPrev_reg <= sdaS;
        end
    end

    // straps caught once, after the sync pipe has filled
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strapS1_reg  <= '0;
            strapS2_reg  <= '0;
            strap_reg    <= '0;
            strapCnt_reg <= 2'h0;
        end else begin
            strapS1_reg <= addrStrap;
            strapS2_reg <= strapS1_reg;
            if (strapCnt_reg != 2'h3) begin
                strapCnt_reg <= strapCnt_reg + 2'h1;
            end
            if (strapCnt_reg == 2'h2) begin
                strap_reg <= strapS2_reg;
            end
        end
    end

    // frame state; start and stop override everything
    always_comb begin
        st_next = st_reg;
        if (stopSeen) begin
            st_next = IDLE;
        end else if (startSeen) begin
            st_next = RECV;
        end else begin
            unique case (st_reg)
                IDLE: st_next = IDLE;
                RECV: if (byteDone) begin
                    st_next = ackByte ? ACK : IDLE;
                end
                ACK:  if (sclFall) begin
                    st_next = rdMode_reg ? SEND : RECV;
                end
                SEND: if (sendEnd) begin
                    st_next = MACK;
                end
                MACK: if (sclFall) begin
                    st_next = mAck_reg ? SEND : IDLE;
                end
            endcase
        end
    end

    // sda drive: ack slots and read data, changed only while scl low
    always_comb begin
        sdaOe_next = sdaOe_reg;
        if (stopSeen | startSeen) begin
            sdaOe_next = 1'b0;
        end else if (byteDone) begin
            sdaOe_next = ackByte;
        end else if (loadTx) begin
            sdaOe_next = ~txByte[7];
        end else if (sendEnd | ackEnd | mackEnd) begin
            sdaOe_next = 1'b0;
        end else if ((st_reg == SEND) & sclFall) begin
            sdaOe_next = ~txShift_reg[6];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg    <= IDLE;
            sdaOe_reg <= 1'b0;
        end else begin
            st_reg    <= st_next;
            sdaOe_reg <= sdaOe_next;
        end
    end

    // bit and byte counting, receive shifter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bitCnt_reg  <= 4'h0;
            shift_reg   <= 8'h00;
            isAddr_reg  <= 1'b0;
            byteCnt_reg <= 4'h0;
        end else begin
            if (startSeen | ackEnd | mackEnd) begin
                bitCnt_reg <= 4'h0;
            end else if ((st_reg == RECV) & sclRise) begin
                bitCnt_reg <= bitCnt_reg + 4'h1;
                shift_reg  <= {shift_reg[6:0], sdaS};
            end else if ((st_reg == SEND) & sclFall) begin
                bitCnt_reg <= bitCnt_reg + 4'h1;
            end
            if (startSeen) begin
                isAddr_reg  <= 1'b1;
                byteCnt_reg <= 4'h0;
            end else if (byteDone) begin
                isAddr_reg <= 1'b0;
                if (takeByte & (byteCnt_reg != BYTE_SAT)) begin
                    byteCnt_reg <= byteCnt_reg + 4'h1;
                end
            end
        end
    end

    // command fields survive a repeated start
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            op_reg     <= 3'h0;
            port_reg   <= '0;
            be_reg     <= '0;
            addr_reg   <= '0;
            wdata_reg  <= 32'h0;
            rdMode_reg <= 1'b0;
        end else if (byteDone & isAddr_reg & addrHit) begin
            rdMode_reg <= shift_reg[0];
        end else if (takeByte) begin
            unique case (byteCnt_reg)
                4'h0: op_reg <= shift_reg[2:0];
                4'h1: port_reg[4:1] <= shift_reg[3:0];
                4'h2: begin
                    port_reg[0]     <= shift_reg[CB2_PSEL0];
                    be_reg          <= shift_reg[CB2_BE_LSB +: BE_W];
                    addr_reg[11:10] <= shift_reg[1:0];
                    addr_reg[1:0]   <= 2'h0;
                end
                4'h3: addr_reg[9:2] <= shift_reg;
                4'h4, 4'h5, 4'h6, 4'h7: wdata_reg[{wIdx, 3'b000} +: 8] <= shift_reg;
                default: ;
            endcase
        end
    end

    // transmit shifter and wrapping byte index
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            txShift_reg <= 8'h00;
            txIdx_reg   <= 2'h0;
            mAck_reg    <= 1'b0;
        end else begin
            if (byteDone & isAddr_reg) begin
                txIdx_reg <= 2'h0;
            end else if (sendEnd) begin
                txIdx_reg <= txIdx_reg + 2'h1;
            end
            if (loadTx) begin
                txShift_reg <= txByte;
            end else if ((st_reg == SEND) & sclFall) begin
                txShift_reg <= {txShift_reg[6:0], 1'b0};
            end
            if ((st_reg == MACK) & sclRise) begin
                mAck_reg <= ~sdaS;
            end
        end
    end

    // register port request, two cycles after the deciding byte so
    // that the last data byte has landed in wdata_reg
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            launch_reg   <= 1'b0;
            launchWr_reg <= 1'b0;
            req_reg      <= 1'b0;
            write_reg    <= 1'b0;
            hold_reg     <= 32'h0;
        end else begin
            launch_reg   <= rdLaunch | wrLaunch;
            launchWr_reg <= wrLaunch;
            if (regAck & req_reg) begin
                req_reg <= 1'b0;
            end else if (launch_reg) begin
                req_reg   <= 1'b1;
                write_reg <= launchWr_reg;
            end
            if (regAck & req_reg & ~write_reg) begin
                hold_reg <= regRdata;
            end
        end
    end

    assign regReq      = req_reg;
    assign regWrite    = write_reg;
    assign regPort     = port_reg;
    assign regAddr     = addr_reg;
    assign regBe       = be_reg;
    assign regWdata    = wdata_reg;
    assign bus.sdaOutS = 1'b0;
    assign bus.sdaOeS  = sdaOe_reg;
endmodule

// ### rtl/irap_host.sv
// host end: i2c master driven by apb registers
// assumes pclk is mclk and a single device on the pair
module irap_host #(
    parameter int QTR = irap_pkg::QTR_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    irap_i2c_if.host         bus
);
    import irap_pkg::*;

    typedef enum logic [1:0] {K_START, K_STOP, K_WBYTE, K_RBYTE} irap_kind_t;

    logic              rd_reg;
    logic [31:0]       tgt_reg;
    logic [31:0]       wdata_reg;
    logic [31:0]       rdata_reg;
    logic [6:0]        slv_reg;
    logic              nak_reg;
    logic              busy_reg;
    logic [31:0]       prdata_reg;
    logic [7:0]        qCnt_reg;
    logic [1:0]        q_reg;
    logic [3:0]        bit_reg;
    logic [3:0]        item_reg;
    logic [1:0]        sdaSync_reg;
    logic              sclLvl_reg;
    logic              sdaLvl_reg;
    logic              sclLvl;
    logic              sdaLvl;
    irap_kind_t        kind;
    logic [7:0]        txB;

    // apb decode; zero wait states
    wire hitCtrl = paddr == OFF_CTRL;
    wire hitTgt  = paddr == OFF_TARGET;
    wire hitWd   = paddr == OFF_WDATA;
    wire hitRd   = paddr == OFF_RDATA;
    wire hitStat = paddr == OFF_STATUS;
    wire hitSlv  = paddr == OFF_SLAVE;
    wire mapped  = hitCtrl | hitTgt | hitWd | hitRd | hitStat | hitSlv;
    wire apbWr   = psel & penable & pwrite & mapped;
    wire go      = apbWr & hitCtrl & pwdata[CTRL_GO] & ~busy_reg;
    wire [31:0] rdMux = hitCtrl ? {30'h0, rd_reg, 1'b0} :
                        hitTgt  ? tgt_reg :
                        hitWd   ? wdata_reg :
                        hitRd   ? rdata_reg :
                        hitStat ? {30'h0, nak_reg, busy_reg} :
                        hitSlv  ? {25'h0, slv_reg} : 32'h0;

    // command bytes formed from the target register, cb0 from the rd bit
    wire [4:0]  port  = tgt_reg[TGT_PORT_LSB +: PSEL_W];
    wire [3:0]  be    = tgt_reg[TGT_BE_LSB +: BE_W];
    wire [11:0] addr  = tgt_reg[TGT_ADDR_LSB +: ADDR_W];
    wire [7:0]  cb0   = {5'h00, rd_reg ? OP_READ : OP_WRITE};
    wire [7:0]  cb1   = {4'h0, port[4:1]};
    wire [7:0]  cb2   = {port[0], 1'b0, be, addr[11:10]};
    wire [7:0]  cb3   = addr[9:2];
    wire [31:0] cmdW  = {cb0, cb1, cb2, cb3};
    wire [1:0]  cbIdx = 2'(item_reg - 4'h2); // item 2 carries cb0
    wire [1:0]  dIdx  = 2'(item_reg - 4'h6);
    wire [3:0]  last  = rd_reg ? ITEM_RD_LAST : ITEM_WR_LAST;
    wire        qTick = qCnt_reg == 8'(QTR - 1);
    wire        sdaS  = sdaSync_reg[1];
    wire        rdAck = item_reg != ITEM_RD_FINAL;

    // item kind: start, bytes, optional repeated start, stop
    always_comb begin
        kind = K_WBYTE;
        txB  = 8'hff;
        if (item_reg == 4'h0 || (rd_reg && item_reg == ITEM_RSTART)) begin
            kind = K_START;
        end else if (item_reg == last) begin
            kind = K_STOP;
        end else if (rd_reg && item_reg >= ITEM_RD_FIRST) begin
            kind = K_RBYTE;
        end else if (item_reg == 4'h1) begin
            txB = {slv_reg, 1'b0};
        end else if (rd_reg && item_reg == 4'h7) begin
            txB = {slv_reg, 1'b1};
        end else if (item_reg <= 4'h5) begin
            txB = cmdW[{~cbIdx, 3'b000} +: 8];
        end else begin
            txB = wdata_reg[{~dIdx, 3'b000} +: 8];
        end
    end

    // line levels per quarter of the bit period
    always_comb begin
        sclLvl = 1'b1;
        sdaLvl = 1'b1;
        if (busy_reg) begin
            unique case (kind)
                K_START: begin
                    sclLvl = (q_reg == 2'h1) || (q_reg == 2'h2);
                    sdaLvl = q_reg <= 2'h1;
                end
                K_STOP: begin
                    sclLvl = q_reg != 2'h0;
                    sdaLvl = q_reg >= 2'h2;
                end
                K_WBYTE: begin
                    sclLvl = (q_reg == 2'h1) || (q_reg == 2'h2);
                    sdaLvl = (bit_reg == BIT_ACK) ? 1'b1 : txB[3'(4'h7 - bit_reg)];
                end
                K_RBYTE: begin
                    sclLvl = (q_reg == 2'h1) || (q_reg == 2'h2);
                    sdaLvl = (bit_reg == BIT_ACK) ? ~rdAck : 1'b1;
                end
            endcase
        end
    end

    // apb registers; go is ignored while busy
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_reg     <= 1'b0;
            tgt_reg    <= {16'h0, 4'h0, BE_RESET, 8'h00};
            wdata_reg  <= 32'h0;
            slv_reg    <= SLV_ADDR_BASE;
            prdata_reg <= 32'h0;
        end else begin
            if (psel & ~penable) begin
                prdata_reg <= rdMux;
            end
            if (apbWr & hitCtrl & ~busy_reg) begin
                rd_reg <= pwdata[CTRL_RD];
            end
            if (apbWr & hitTgt & ~busy_reg) begin
                tgt_reg <= pwdata;
            end
            if (apbWr & hitWd & ~busy_reg) begin
                wdata_reg <= pwdata;
            end
            if (apbWr & hitSlv & ~busy_reg) begin
                slv_reg <= pwdata[6:0];
            end
        end
    end

    // bit engine: quarter ticks, bits, items
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busy_reg    <= 1'b0;
            nak_reg     <= 1'b0;
            qCnt_reg    <= 8'h00;
            q_reg       <= 2'h0;
            bit_reg     <= 4'h0;
            item_reg    <= 4'h0;
            rdata_reg   <= 32'h0;
            sdaSync_reg <= 2'h3;
            sclLvl_reg  <= 1'b1;
            sdaLvl_reg  <= 1'b1;
        end else begin
            sdaSync_reg <= {sdaSync_reg[0], bus.sda};
            sclLvl_reg  <= sclLvl;
            sdaLvl_reg  <= sdaLvl;
            qCnt_reg    <= (qTick | ~busy_reg) ? 8'h00 : qCnt_reg + 8'h01;
            if (go) begin
                busy_reg <= 1'b1;
                nak_reg  <= 1'b0;
                q_reg    <= 2'h0;
                bit_reg  <= 4'h0;
                item_reg <= 4'h0;
            end else if (busy_reg & qTick) begin
                q_reg <= q_reg + 2'h1;
                if (q_reg == 2'h2) begin
                    if (kind == K_WBYTE && bit_reg == BIT_ACK && sdaS) begin
                        nak_reg <= 1'b1;
                    end
                    if (kind == K_RBYTE && bit_reg != BIT_ACK) begin
                        rdata_reg <= {rdata_reg[30:0], sdaS};
                    end
                end
                if (q_reg == 2'h3) begin
                    if ((kind == K_START) || (kind == K_STOP) || (bit_reg == BIT_ACK)) begin
                        bit_reg  <= 4'h0;
                        item_reg <= (kind == K_WBYTE && nak_reg) ? last : item_reg + 4'h1;
                        busy_reg <= kind != K_STOP;
                    end else begin
                        bit_reg <= bit_reg + 4'h1;
                    end
                end
            end
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = 1'b1;
    assign pslverr     = psel & penable & ~mapped;
    assign bus.sclOutM = 1'b0;
    assign bus.sclOeM  = ~sclLvl_reg;
    assign bus.sdaOutM = 1'b0;
    assign bus.sdaOeM  = ~sdaLvl_reg;
endmodule

// ### rtl/irap_i2c_if.sv
// open-drain i2c pair joining the host and the device end
// each end only pulls low; released lines read high
interface irap_i2c_if;
    logic sclOutM;
    logic sclOeM;
    logic sdaOutM;
    logic sdaOeM;
    logic sdaOutS;
    logic sdaOeS;
    logic scl;
    logic sda;
    // wired-and with pull-ups
    assign scl = ~sclOeM | sclOutM;
    assign sda = ~(sdaOeM & ~sdaOutM) & ~(sdaOeS & ~sdaOutS);
    modport dev  (input scl, input sda, output sdaOutS, output sdaOeS);
    modport host (input scl, input sda, output sclOutM, output sclOeM,
                  output sdaOutM, output sdaOeM);
endinterface

// ### rtl/irap_pkg.sv
// constants shared by both ends of the i2c register access port
// assumes a 100 MHz mclk on both ends and an open-drain i2c pair
package irap_pkg;
    // link framing and command byte layout
    localparam logic [6:0] SLV_ADDR_BASE = 7'h68;
    localparam logic [2:0] OP_WRITE      = 3'h3;
    localparam logic [2:0] OP_READ       = 3'h4;
    localparam int         PSEL_W        = 5;
    localparam int         ADDR_W        = 12;
    localparam int         BE_W          = 4;
    localparam int         STRAP_W       = 3;
    localparam logic [3:0] CMD_LAST      = 4'h3;
    localparam logic [3:0] DATA_LAST     = 4'h7;
    localparam logic [3:0] BYTE_SAT      = 4'h8;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    localparam int         CB2_PSEL0     = 7;
    localparam int         CB2_BE_LSB    = 2;
    // host apb register map, byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_TARGET    = 8'h04;
    localparam logic [7:0] OFF_WDATA     = 8'h08;
    localparam logic [7:0] OFF_RDATA     = 8'h0c;
    localparam logic [7:0] OFF_STATUS    = 8'h10;
    localparam logic [7:0] OFF_SLAVE     = 8'h14;
    localparam int         CTRL_GO       = 0;
    localparam int         CTRL_RD       = 1;
    localparam int         TGT_PORT_LSB  = 0;
    localparam int         TGT_BE_LSB    = 8;
    localparam int         TGT_ADDR_LSB  = 16;
    localparam int         STAT_BUSY     = 0;
    localparam int         STAT_NAK      = 1;
    localparam logic [3:0] BE_RESET      = 4'hf;
    // host item sequence: write packet 0..10, read packets 0..12
    localparam logic [3:0] ITEM_WR_LAST  = 4'ha;
    localparam logic [3:0] ITEM_RD_LAST  = 4'hc;
    localparam logic [3:0] ITEM_RSTART   = 4'h6;
    localparam logic [3:0] ITEM_RD_FIRST = 4'h8;
    localparam logic [3:0] ITEM_RD_FINAL = 4'hb;
    // scl timing
    localparam int         MCLK_NS       = 10;
    localparam int         SCL_PERIOD_NS = 160;
    localparam int         QTR_CYC       = (SCL_PERIOD_NS + 4 * MCLK_NS - 1) / (4 * MCLK_NS);
endpackage
